/* File: rtl/asr_defines.svh */
/*
 * Shared constants of the serial converter readout link: clock rates,
 * link timing, frame layout and the controller register map.
 * Assumes inclusion by bare name, with this folder on the include path.
 */
`ifndef ASR_DEFINES_SVH
`define ASR_DEFINES_SVH

// ============================================================
// clock and link timing
// ============================================================
`define ASR_CLK_PERIOD_NS   50
`define ASR_CLK_FREQ_KHZ    20000
`define ASR_SCLK_FREQ_KHZ   1000
// half period of the shift clock in system cycles
`define ASR_SCLK_HALF_CYC   (`ASR_CLK_FREQ_KHZ / (2 * `ASR_SCLK_FREQ_KHZ))
// longest conversion time, a least wait: rounded up
`define ASR_CONV_MAX_NS     8500
`define ASR_CONV_MAX_CYC    ((`ASR_CONV_MAX_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)
// converter's own conversion time, kept below the maximum: rounded down
`define ASR_DEV_CONV_NS     6000
`define ASR_DEV_CONV_CYC    (`ASR_DEV_CONV_NS / `ASR_CLK_PERIOD_NS)
// chip select high time between frames (track time), rounded up
`define ASR_GAP_NS          1500
`define ASR_GAP_CYC         ((`ASR_GAP_NS + `ASR_CLK_PERIOD_NS - 1) / `ASR_CLK_PERIOD_NS)

// ============================================================
// frame layout
// ============================================================
`define ASR_RES_BITS        12
`define ASR_FRAME_BITS      16
`define ASR_BYTE_BITS       8

// ============================================================
// controller register map (byte addresses)
// ============================================================
`define ASR_ADDR_W          8
`define ASR_OFS_CTRL        8'h00
`define ASR_OFS_STATUS      8'h04
`define ASR_OFS_DATA        8'h08
`define ASR_CTRL_START      0
`define ASR_CTRL_PWR_ON     1
`define ASR_CTRL_TIMED      2
`define ASR_STAT_BUSY       0
`define ASR_STAT_DONE       1
`define ASR_CTRL_RESET      1'b1

`endif

/* File: rtl/asr_pkg.sv */
/*
 * Types of the converter readout link: the result word shared by both ends, the controller's states.
 * Assumes nothing beyond the defines header.
 */
package asr_pkg;
    // ============================================================
    // controller sequencing states
    // ============================================================
    typedef enum logic [3:0] {
        ASR_IDLE   = 4'b0001,
        ASR_SELECT = 4'b0010,
        ASR_SHIFT  = 4'b0100,
        ASR_FINISH = 4'b1000
    } asr_state_t;

    typedef logic [11:0] asr_result_t;
endpackage

/* File: rtl/asr_link_if.sv */
/*
 * Pin-level link between the readout controller and the converter.
 * Assumes the controller makes chip select, shift clock and power-down.
 */
interface asr_link_if;
    logic cs_n;          // active-low chip select
    logic sclk;          // shift clock, idles low
    logic dout;          // converter serial data
    logic power_down_n;  // active-low shutdown, high to convert

    modport host (
        output cs_n,
        output sclk,
        output power_down_n,
        input  dout
    );
    modport adc (
        input  cs_n,
        input  sclk,
        input  power_down_n,
        output dout
    );
endinterface

/* File: rtl/asr_sync.sv */
/*
 * Two-stage level synchroniser.
 * Assumes an input from outside the CLOCK domain; output is one bit.
 */
module asr_sync (
    input  wire logic CLOCK,
    input  wire logic RESETN,
    input  wire logic d,
    output logic      q
);
    logic meta_r;
    logic meta_nxt;
    logic q_nxt;

    // ============================================================
    // two flops, first one read only by the second
    // ============================================================
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end
endmodule

/* File: rtl/asr_adc.sv */
/*
 * Converter end of the readout link: conversion timing on CLOCK,
 * serial shift-out on the link's own clock.
 * Assumes the controller keeps chip select low for a whole frame and
 * holds the shift clock low until the start bit is seen.
 */
`include "asr_defines.svh"

module asr_adc (
    input  wire logic           CLOCK,
    input  wire logic           RESETN,
    asr_link_if.adc             link,
    input  wire asr_pkg::asr_result_t SAMPLE,
    output logic                BUSY
);
    import asr_pkg::*;

    logic        cs_n_s;
    logic        pwr_s;
    logic        cs_n_d_r,  cs_n_d_nxt;
    logic        busy_r,    busy_nxt;
    logic        eoc_r,     eoc_nxt;
    logic [7:0]  conv_r,    conv_nxt;
    asr_result_t word_r,    word_nxt;
    logic [4:0]  idx_r,     idx_nxt;
    logic        serial_bit;

    // ============================================================
    // pin synchronisers
    // ============================================================
    asr_sync u_sync_cs (.CLOCK(CLOCK), .RESETN(RESETN), .d(link.cs_n), .q(cs_n_s));
    asr_sync u_sync_pd (.CLOCK(CLOCK), .RESETN(RESETN), .d(link.power_down_n), .q(pwr_s));

    // ============================================================
    // conversion control on CLOCK
    // ============================================================
    always_comb begin
        cs_n_d_nxt = cs_n_s;
        busy_nxt   = busy_r;
        eoc_nxt    = eoc_r;
        conv_nxt   = conv_r;
        word_nxt   = word_r;
        if (cs_n_s || !pwr_s) begin
            // frame over or shut down: drop result flag and any conversion
            busy_nxt = 1'b0;
            eoc_nxt  = 1'b0;
        end else if (cs_n_d_r) begin
            // falling chip select: sample and start converting
            busy_nxt = 1'b1;                                          // R7
            eoc_nxt  = 1'b0;
            conv_nxt = 8'h00;
            word_nxt = SAMPLE;
        end else if (busy_r) begin
            conv_nxt = conv_r + 8'h01;
            if (conv_r == 8'(`ASR_DEV_CONV_CYC - 1)) begin
                busy_nxt = 1'b0;
                eoc_nxt  = 1'b1;                                      // R9
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            cs_n_d_r <= 1'b1;
            busy_r   <= 1'b0;
            eoc_r    <= 1'b0;
            conv_r   <= 8'h00;
            word_r   <= 12'h000;
        end else begin
            cs_n_d_r <= cs_n_d_nxt;
            busy_r   <= busy_nxt;
            eoc_r    <= eoc_nxt;
            conv_r   <= conv_nxt;
            word_r   <= word_nxt;
        end
    end

    // ============================================================
    // bit index on the link clock, cleared by the frame's own select
    // ============================================================
    // saturates at the frame length so extra clocks only give zeros
    always_comb begin
        idx_nxt = idx_r;
        if (idx_r != 5'(`ASR_FRAME_BITS)) begin
            idx_nxt = idx_r + 5'h01;
        end
    end

    // advances after each falling edge so bits are stable at the rise
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            idx_r <= 5'h00;
        end else begin
            idx_r <= idx_nxt;                                         // R14
        end
    end

    // ============================================================
    // serial output: start bit, result msb first, then zero padding
    // ============================================================
    // word_r is quasi-static: it settles well before eoc_r rises
    always_comb begin
        serial_bit = 1'b0;
        if (idx_r == 5'h00) begin
            serial_bit = eoc_r;                                       // R3 R9
        end else if (idx_r <= 5'(`ASR_RES_BITS)) begin
            serial_bit = word_r[4'(`ASR_RES_BITS - idx_r)];           // R3 R4
        end
    end

    assign link.dout = !link.cs_n && serial_bit;                      // R4
    assign BUSY      = busy_r;
endmodule

/* File: rtl/asr_host.sv */
/*
 * Readout controller end: APB register slave that runs one converter
 * frame per start command taken while idle and powered, and keeps the right-justified result.
 * Assumes the converter answers on the link as described below and
 * that APB is clocked by CLOCK.
 */
// Behaviour
// R1: shift clock 1 MHz, idles low, mode 0
// R2: no clocking before data line goes high
// R3: first byte: start bit, result 11..5
// R4: second byte: result 4..0, three zeros
// R5: two bytes under one chip select
// R6: keep twelve result bits, right-justified
// R7: falling chip select starts a conversion
// R8: optional fixed 8.5 us wait instead
// R9: start bit then result on successive clocks
// R10: rising start bit marks frame start
// R11: shutdown input held high for converting
// R12: raise clock, shift data into low bit
// R13: clock low while deselected or waiting
// R14: converter changes data after falling edge
`include "asr_defines.svh"

module asr_host (
    input  wire logic        CLOCK,
    input  wire logic        RESETN,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    asr_link_if.host         link
);
    import asr_pkg::*;

    asr_state_t  state_r,   state_nxt;
    logic        cs_n_r,    cs_n_nxt;
    logic        sclk_r,    sclk_nxt;
    logic        pwr_r,     pwr_nxt;
    logic        timed_r,   timed_nxt;
    logic        done_r,    done_nxt;
    logic [4:0]  div_r,     div_nxt;
    logic [4:0]  bits_r,    bits_nxt;
    logic [7:0]  wait_r,    wait_nxt;
    logic [15:0] shreg_r,   shreg_nxt;
    asr_result_t data_r,    data_nxt;
    logic [31:0] prdata_r,  prdata_nxt;
    logic        pslverr_r, pslverr_nxt;
    logic        dout_s;
    logic        setup;
    logic        wr_acc;
    logic        start_cmd;
    logic        done_clr;
    logic        done_set;
    logic        mapped;

    // ============================================================
    // data line synchroniser
    // ============================================================
    asr_sync u_sync_dout (.CLOCK(CLOCK), .RESETN(RESETN), .d(link.dout), .q(dout_s));

    // ============================================================
    // APB decode
    // ============================================================
    // zero-wait slave: read data is prepared in the setup cycle
    always_comb begin
        setup     = PSEL && !PENABLE;
        wr_acc    = PSEL && PENABLE && PWRITE;
        mapped    = (PADDR == `ASR_OFS_CTRL) || (PADDR == `ASR_OFS_STATUS) ||
                    (PADDR == `ASR_OFS_DATA);
        start_cmd = wr_acc && (PADDR == `ASR_OFS_CTRL) && PWDATA[`ASR_CTRL_START];
        done_clr  = wr_acc && (PADDR == `ASR_OFS_STATUS) && PWDATA[`ASR_STAT_DONE];
    end

    always_comb begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup) begin
            pslverr_nxt = !mapped;
            prdata_nxt  = 32'h0000_0000;
            unique case (PADDR)
                `ASR_OFS_CTRL: begin
                    prdata_nxt[`ASR_CTRL_PWR_ON] = pwr_r;
                    prdata_nxt[`ASR_CTRL_TIMED]  = timed_r;
                end
                `ASR_OFS_STATUS: begin
                    prdata_nxt[`ASR_STAT_BUSY] = (state_r != ASR_IDLE);
                    prdata_nxt[`ASR_STAT_DONE] = done_r;
                end
                `ASR_OFS_DATA: begin
                    prdata_nxt[11:0] = data_r;
                end
                default: begin
                    prdata_nxt = 32'h0000_0000;
                end
            endcase
        end
    end

    // ============================================================
    // control bits and sticky done flag
    // ============================================================
    // a frame ending in the clearing cycle keeps its done flag
    always_comb begin
        pwr_nxt   = pwr_r;
        timed_nxt = timed_r;
        if (wr_acc && (PADDR == `ASR_OFS_CTRL)) begin
            pwr_nxt   = PWDATA[`ASR_CTRL_PWR_ON];                     // R11
            timed_nxt = PWDATA[`ASR_CTRL_TIMED];
        end
        done_nxt = (done_r && !done_clr) || done_set;
    end

    // ============================================================
    // frame sequencer
    // ============================================================
    always_comb begin
        state_nxt = state_r;
        cs_n_nxt  = cs_n_r;
        sclk_nxt  = 1'b0;                                             // R13
        div_nxt   = div_r;
        bits_nxt  = bits_r;
        wait_nxt  = wait_r;
        shreg_nxt = shreg_r;
        data_nxt  = data_r;
        done_set  = 1'b0;
        unique case (state_r)
            ASR_IDLE: begin
                // a start while powered down is ignored
                if (start_cmd && pwr_r) begin
                    state_nxt = ASR_SELECT;
                    cs_n_nxt  = 1'b0;                                 // R7
                    wait_nxt  = 8'h00;
                    shreg_nxt = 16'h0000;
                    bits_nxt  = 5'h00;
                end
            end
            ASR_SELECT: begin
                // either watch the data line or wait the worst case
                wait_nxt = wait_r + 8'h01;
                if (timed_r ? (wait_r == 8'(`ASR_CONV_MAX_CYC - 1))   // R8
                            : dout_s) begin                           // R2 R10
                    state_nxt = ASR_SHIFT;
                    div_nxt   = 5'h00;
                end
            end
            ASR_SHIFT: begin
                // one unbroken 16-clock burst covers both bytes
                sclk_nxt = sclk_r;
                div_nxt  = div_r + 5'h01;
                if (div_r == 5'(`ASR_SCLK_HALF_CYC - 1)) begin        // R1
                    div_nxt = 5'h00;
                    if (!sclk_r) begin
                        sclk_nxt  = 1'b1;
                        shreg_nxt = {shreg_r[14:0], dout_s};          // R12
                        bits_nxt  = bits_r + 5'h01;
                    end else begin
                        sclk_nxt = 1'b0;
                        if (bits_r == 5'(`ASR_FRAME_BITS)) begin      // R5
                            state_nxt = ASR_FINISH;
                            cs_n_nxt  = 1'b1;
                            wait_nxt  = 8'h00;
                        end
                    end
                end
            end
            ASR_FINISH: begin
                // drop start bit and padding, hold select high for tracking
                if (wait_r == 8'h00) begin
                    data_nxt = shreg_r[14:3];                         // R6
                    done_set = 1'b1;
                end
                wait_nxt = wait_r + 8'h01;
                if (wait_r == 8'(`ASR_GAP_CYC - 1)) begin
                    state_nxt = ASR_IDLE;
                end
            end
            default: begin
                state_nxt = ASR_IDLE;
                cs_n_nxt  = 1'b1;
            end
        endcase
    end

    // ============================================================
    // registers
    // ============================================================
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            state_r   <= ASR_IDLE;
            cs_n_r    <= 1'b1;
            sclk_r    <= 1'b0;
            pwr_r     <= `ASR_CTRL_RESET;
            timed_r   <= 1'b0;
            done_r    <= 1'b0;
            div_r     <= 5'h00;
            bits_r    <= 5'h00;
            wait_r    <= 8'h00;
            shreg_r   <= 16'h0000;
            data_r    <= 12'h000;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            PREADY    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            cs_n_r    <= cs_n_nxt;
            sclk_r    <= sclk_nxt;
            pwr_r     <= pwr_nxt;
            timed_r   <= timed_nxt;
            done_r    <= done_nxt;
            div_r     <= div_nxt;
            bits_r    <= bits_nxt;
            wait_r    <= wait_nxt;
            shreg_r   <= shreg_nxt;
            data_r    <= data_nxt;
            prdata_r  <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            PREADY    <= 1'b1;
        end
    end

    // ============================================================
    // outputs, all from flops
    // ============================================================
    assign PRDATA            = prdata_r;
    assign PSLVERR           = pslverr_r;
    assign link.cs_n         = cs_n_r;
    assign link.sclk         = sclk_r;
    assign link.power_down_n = pwr_r;
endmodule

/* File: verification/asr_link_chk.sv */
/*
 * Checker of the converter readout link wires.
 * Assumes the controller's CLOCK and RESETN and the link's four wires as
 * plain inputs; instantiated beside the link in the bench top.
 */
module asr_link_chk (
    input wire logic CLOCK,
    input wire logic RESETN,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic dout,
    input wire logic power_down_n
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] rises_r;
    logic [4:0] rises_nxt;
    logic       sclk_r;
    logic       rise;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    // ============================================================
    // shift clock rises within the current frame
    // ============================================================
    // cleared while deselected so each frame counts from zero
    always_comb begin
        rise      = sclk && !sclk_r;
        rises_nxt = cs_n ? 5'h00 : rises_r + {4'h0, rise};
    end

    // register only
    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            rises_r <= 5'h00;
            sclk_r  <= 1'b0;
        end else begin
            rises_r <= rises_nxt;
            sclk_r  <= sclk;
        end
    end

    // ============================================================
    // link properties
    // ============================================================
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("shift clock high while deselected");
    a_no_early_clk: assert property (!cs_n && !dout && rises_r == 5'h00 |-> !sclk)
        else $error("shift clock before end of conversion");
    a_high_time: assert property ($rose(sclk) |=> sclk [*8] ##1 sclk ##1 !sclk)
        else $error("shift clock high time wrong");
    a_low_time: assert property ($fell(sclk) && !cs_n |=> !sclk [*8] ##1 !sclk ##1 sclk)
        else $error("shift clock low time wrong");
    a_frame_len: assert property ($rose(cs_n) |-> rises_r == 5'h10)
        else $error("frame not sixteen clocks");
    a_start_bit: assert property (rise && rises_r == 5'h00 |-> dout)
        else $error("start bit missing at first rise");
    a_pad_zero: assert property (rise && rises_r >= 5'h0D |-> !dout)
        else $error("padding bit not zero");
    a_data_stable: assert property (sclk && $past(sclk) && !cs_n |-> $stable(dout))
        else $error("data changed while clock high");
    a_powered_conv: assert property (!cs_n |-> power_down_n)
        else $error("frame while powered down");
    a_conv_time: assert property ($fell(cs_n) |-> ##[100:140] dout)
        else $error("conversion did not finish");
endmodule

/* File: verification/asr_host_tb.sv */
/*
 * Self-checking bench: controller and converter joined over the link,
 * software side driven over APB, converter input from fixed corner values and random draws.
 * Assumes the design files and the defines header on the include path.
 */
`include "asr_defines.svh"
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin errors++; \
    $display("[ERR] %0t %s", $time, m); end end

module asr_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import asr_pkg::*;

    logic        clock = 1'b0;
    logic        resetn, psel, penable, pwrite, pready, pslverr, adc_busy;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [15:0] shreg;
    asr_result_t sample;
    int          errors, comparisons, nbits, frames;
    time         t_fall, t_rise;

    asr_link_if lnk ();

    // ============================================================
    // clock, design ends and checker
    // ============================================================
    always #25 clock = ~clock;

    asr_host asr_host_i (.CLOCK(clock), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .link(lnk));
    asr_adc asr_adc_i (.CLOCK(clock), .RESETN(resetn), .link(lnk), .SAMPLE(sample),
        .BUSY(adc_busy));
    asr_link_chk asr_link_chk_i (.CLOCK(clock), .RESETN(resetn), .cs_n(lnk.cs_n),
        .sclk(lnk.sclk), .dout(lnk.dout), .power_down_n(lnk.power_down_n));

    // ============================================================
    // wire monitor: frames and bits seen at each shift clock rise
    // ============================================================
    always @(negedge lnk.cs_n) begin
        nbits = 0;
        frames++;
        t_fall = $time;
    end

    // data settled half a clock earlier, so the rise is safe to sample on
    always @(posedge lnk.sclk) if (!lnk.cs_n) begin
        if (nbits == 0) t_rise = $time;
        shreg = {shreg[14:0], lnk.dout};
        nbits++;
    end

    // ============================================================
    // bus tasks and expectations
    // ============================================================
    // holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        er;
        apb(1'b1, a, d, rd, er);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
        logic [31:0] rd;
        logic        er;
        apb(1'b0, a, 32'h0, rd, er);
        `CHK(rd, e, "read data")
        `CHK(er, ee, "slave error")
    endtask

    function automatic logic [15:0] exp_frame(asr_result_t s);
        return {1'b1, s, 3'b000};
    endfunction

    // one frame; again issues a second start while busy, which must be lost
    task automatic conv(input asr_result_t s, input logic timed, input logic again);
        logic [31:0] st;
        logic [15:0] e;
        logic        er;
        int          n, f0;
        n = 0;
        f0 = frames;
        e = exp_frame(s);
        @(posedge clock);
        sample <= s;
        wr(`ASR_OFS_CTRL, {29'h0, timed, 2'b11});
        if (again) wr(`ASR_OFS_CTRL, {29'h0, timed, 2'b11});
        do begin
            apb(1'b0, `ASR_OFS_STATUS, 32'h0, st, er);
            n++;
        end while (st[0] !== 1'b0 && n < 400);
        `CHK(st, 32'h2, "done status")
        rd_chk(`ASR_OFS_DATA, {20'h0, s}, 1'b0);
        `CHK(shreg[15:8], e[15:8], "first byte")
        `CHK(shreg[7:0], e[7:0], "second byte")
        `CHK(nbits, 16, "clock count")
        `CHK(frames, f0 + 1, "frame count")
        `CHK(t_rise - t_fall >= `ASR_CONV_MAX_NS, timed, "wait before clock")
        `CHK(adc_busy, 1'b0, "converter idle")
        wr(`ASR_OFS_STATUS, 32'h2);
        rd_chk(`ASR_OFS_STATUS, 32'h0, 1'b0);
    endtask

    task automatic stop_test;
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ============================================================
    // main sequence and watchdog
    // ============================================================
    initial begin
        int f;
        resetn  = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        sample  = 12'h000;
        void'($urandom(32'h8510C706));
        repeat (10) @(posedge clock);
        @(negedge clock);
        `CHK({lnk.cs_n, lnk.sclk, lnk.power_down_n}, 3'b101, "link idle in reset")
        @(posedge clock);
        resetn <= 1'b1;
        rd_chk(`ASR_OFS_CTRL, 32'h2, 1'b0);
        rd_chk(`ASR_OFS_STATUS, 32'h0, 1'b0);
        rd_chk(`ASR_OFS_DATA, 32'h0, 1'b0);
        rd_chk(8'h0C, 32'h0, 1'b1);
        // corner values first, then random ones
        conv(12'h000, 1'b0, 1'b0);
        conv(12'hFFF, 1'b1, 1'b0);
        conv(12'hA5A, 1'b0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            conv(asr_result_t'($urandom()), i[0], 1'b0);
        end
        // powered down: start must be refused and no frame run
        f = frames;
        wr(`ASR_OFS_CTRL, 32'h0);
        @(negedge clock);
        `CHK(lnk.power_down_n, 1'b0, "power down pin")
        wr(`ASR_OFS_CTRL, 32'h1);
        rd_chk(`ASR_OFS_STATUS, 32'h0, 1'b0);
        rd_chk(`ASR_OFS_CTRL, 32'h0, 1'b0);
        `CHK(frames, f, "no frame when off")
        wr(`ASR_OFS_CTRL, 32'h2);
        conv(12'h801, 1'b0, 1'b0);
        stop_test;
    end

    // a hang counts as a mismatch
    initial begin
        #2000000;
        errors++;
        stop_test;
    end
endmodule
